//--- mbi_pkg.sv
// constants, layouts and types of the macroblock inline field parser
// assumes one 200 mhz clock and an axi4-lite master with 32-bit data
package mbi_pkg;
    localparam int ADDR_W = 8;
    // byte offsets of the register words
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DW7 = 8'h04;
    localparam logic [7:0] OFF_DW8 = 8'h08;
    localparam logic [7:0] OFF_DW9 = 8'h0c;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] OFF_INTER = 8'h14;
    localparam logic [7:0] OFF_SCAN = 8'h18;
    // control word fields
    localparam int CTRL_INTRA_BIT = 0;
    localparam int CTRL_LTF_BIT = 1;
    localparam int CTRL_SHAPE_LSB = 2;
    localparam int CTRL_MBTYPE_LSB = 8;
    localparam int CTRL_SEL_LSB = 16;
    localparam int CTRL_RASTER_LSB = 20;
    localparam int CTRL_START_BIT = 31;
    localparam logic [31:0] CTRL_WMASK = 32'h00ff1f0f;
    // intra structure byte, low byte of inline dword 9
    localparam int AV_LEFT_ROW7 = 7;
    localparam int AV_LEFT_UP = 6;
    localparam int AV_LEFT_LO = 5;
    localparam int AV_TOP = 4;
    localparam int AV_TOP_RIGHT = 3;
    localparam int AV_TOP_LEFT = 2;
    localparam int CHROMA_LSB = 0;
    localparam int SUB_LSB = 8;
    localparam logic [4:0] MBTYPE_BIG_MIN = 5'h01;
    localparam logic [4:0] MBTYPE_BIG_MAX = 5'h18;
    localparam logic [3:0] BIG_CODE_MAX = 4'h3;
    localparam logic [3:0] DIR_CODE_MAX = 4'h8;
    // status word fields
    localparam int STAT_VALID_BIT = 0;
    localparam int STAT_RSV_BIT = 1;
    localparam int STAT_MBZ_BIT = 2;
    localparam int STAT_INTRA_BIT = 3;
    localparam int STAT_SIZE_LSB = 4;
    localparam int STAT_CODE_LSB = 8;
    localparam int STAT_MODE_LSB = 12;
    localparam int STAT_CHROMA_LSB = 16;
    localparam int STAT_AVAIL_LSB = 24;
    // inter result word fields
    localparam int INT_L0_LSB = 0;
    localparam int INT_L1_LSB = 8;
    localparam int INT_SUB_LSB = 16;
    localparam int INT_UNUSED_BIT = 18;
    localparam int INT_MBZ_BIT = 19;
    localparam int INT_ALL_LSB = 24;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_PARSE = 1'b1} mbi_state_e;
    typedef enum logic [1:0] {
        SZ_16 = 2'b00, SZ_8 = 2'b01, SZ_4 = 2'b10, SZ_NONE = 2'b11
    } mbi_size_e;
    typedef enum logic [3:0] {
        LM_VERT = 4'h0, LM_HORIZ = 4'h1, LM_DC = 4'h2, LM_DDL = 4'h3,
        LM_DDR = 4'h4, LM_VR = 4'h5, LM_HD = 4'h6, LM_VL = 4'h7,
        LM_HU = 4'h8, LM_PLANE = 4'h9, LM_RSV = 4'hf
    } mbi_luma_e;
    typedef enum logic [1:0] {
        CH_DC = 2'b00, CH_HORIZ = 2'b01, CH_VERT = 2'b10, CH_PLANE = 2'b11
    } mbi_chroma_e;
    typedef enum logic [1:0] {
        SH_16X16 = 2'b00, SH_16X8 = 2'b01, SH_8X16 = 2'b10, SH_8X8 = 2'b11
    } mbi_shape_e;

    // raster position row*4+col to quadrant-recursive block number
    function automatic logic [3:0] raster_to_block(input logic [3:0] pos);
        raster_to_block = {pos[3], pos[1], pos[2], pos[0]};
    endfunction
endpackage

//--- mbi_dec_if.sv
// decoded inline fields passed from the two decoders to the parser top
// assumes both decoders are combinational on the top's stored words
interface mbi_dec_if;
    logic [5:0] avail;
    mbi_pkg::mbi_chroma_e chroma;
    mbi_pkg::mbi_size_e size;
    logic [3:0] luma_code;
    mbi_pkg::mbi_luma_e luma_mode;
    logic intra_rsv_err;
    logic intra_mbz_err;
    logic [1:0] sub_mode;
    logic [7:0] sub_modes;
    logic [7:0] ref_l0;
    logic [7:0] ref_l1;
    logic unused_err;
    logic inter_mbz_err;
    modport intra_src (output avail, chroma, size, luma_code, luma_mode,
        intra_rsv_err, intra_mbz_err);
    modport inter_src (output sub_mode, sub_modes, ref_l0, ref_l1,
        unused_err, inter_mbz_err);
    modport sink (input avail, chroma, size, luma_code, luma_mode,
        intra_rsv_err, intra_mbz_err, sub_mode, sub_modes, ref_l0, ref_l1,
        unused_err, inter_mbz_err);
endinterface

//--- mbi_intra_dec.sv
// intra macroblock field decoder: availability, chroma and luma modes
// assumes stable inputs from registers; purely combinational
module mbi_intra_dec (
    input wire logic [31:0] dw7,
    input wire logic [31:0] dw8,
    input wire logic [31:0] dw9,
    input wire logic [4:0] mb_type,
    input wire logic ltf,
    input wire logic [3:0] sel,
    mbi_dec_if.intra_src dec
);
    logic [63:0] luma;

    function automatic mbi_pkg::mbi_luma_e dir_mode(input logic [3:0] code);
        if (code <= mbi_pkg::DIR_CODE_MAX) begin
            dir_mode = mbi_pkg::mbi_luma_e'(code);
        end else begin
            dir_mode = mbi_pkg::LM_RSV;
        end
    endfunction

    assign luma = {dw8, dw7};

    always_comb begin
        dec.avail = {dw9[mbi_pkg::AV_LEFT_ROW7], dw9[mbi_pkg::AV_LEFT_UP],
            dw9[mbi_pkg::AV_LEFT_LO],
            dw9[mbi_pkg::AV_TOP], dw9[mbi_pkg::AV_TOP_RIGHT],
            dw9[mbi_pkg::AV_TOP_LEFT]};
        // byte sits in dword 9 low bits, two low bits pick chroma
        dec.chroma = mbi_pkg::mbi_chroma_e'(dw9[mbi_pkg::CHROMA_LSB +: 2]);
        dec.intra_mbz_err = (dw9[31:8] != 24'h0);
        dec.luma_code = 4'h0;
        dec.luma_mode = mbi_pkg::LM_RSV;
        dec.intra_rsv_err = 1'b1;
        if (mb_type == 5'h00) begin
            dec.size = ltf ? mbi_pkg::SZ_8 : mbi_pkg::SZ_4;
        end else if (mb_type >= mbi_pkg::MBTYPE_BIG_MIN &&
                     mb_type <= mbi_pkg::MBTYPE_BIG_MAX && !ltf) begin
            dec.size = mbi_pkg::SZ_16;
        end else begin
            dec.size = mbi_pkg::SZ_NONE;
        end
        case (dec.size)
            mbi_pkg::SZ_16: begin
                dec.luma_code = luma[3:0];
                dec.intra_mbz_err = dec.intra_mbz_err | (luma[63:4] != 60'h0);
                dec.intra_rsv_err = luma[3:0] > mbi_pkg::BIG_CODE_MAX;
                case (luma[3:0])
                    4'h0: dec.luma_mode = mbi_pkg::LM_VERT;
                    4'h1: dec.luma_mode = mbi_pkg::LM_HORIZ;
                    4'h2: dec.luma_mode = mbi_pkg::LM_DC;
                    4'h3: dec.luma_mode = mbi_pkg::LM_PLANE;
                    default: dec.luma_mode = mbi_pkg::LM_RSV;
                endcase
            end
            mbi_pkg::SZ_8: begin
                dec.luma_code = luma[{sel[1:0], 2'b00} +: 4];
                dec.intra_mbz_err = dec.intra_mbz_err | (luma[63:16] != 48'h0);
                dec.luma_mode = dir_mode(dec.luma_code);
                dec.intra_rsv_err = dec.luma_code > mbi_pkg::DIR_CODE_MAX;
            end
            mbi_pkg::SZ_4: begin
                // word n/8, nibble n mod 8 lands on bit 4n of the pair
                dec.luma_code = luma[{sel, 2'b00} +: 4];
                dec.luma_mode = dir_mode(dec.luma_code);
                dec.intra_rsv_err = dec.luma_code > mbi_pkg::DIR_CODE_MAX;
            end
            default: begin
                dec.intra_rsv_err = 1'b1;
            end
        endcase
    end
endmodule

//--- mbi_inter_dec.sv
// inter macroblock field decoder: sub-partition modes and ref indices
// assumes stable inputs from registers; purely combinational
module mbi_inter_dec (
    input wire logic [31:0] dw7,
    input wire logic [31:0] dw8,
    input wire logic [31:0] dw9,
    input wire logic [1:0] shape,
    input wire logic [1:0] sel,
    mbi_dec_if.inter_src dec
);
    function automatic logic [7:0] byte_of(input logic [31:0] w,
                                           input logic [1:0] idx);
        byte_of = w[{idx, 3'b000} +: 8];
    endfunction

    always_comb begin
        dec.sub_modes = dw7[mbi_pkg::SUB_LSB +: 8];
        dec.sub_mode = dec.sub_modes[{sel, 1'b0} +: 2];
        dec.ref_l0 = byte_of(dw8, sel);
        dec.ref_l1 = byte_of(dw9, sel);
        dec.inter_mbz_err = (dw7[31:16] != 16'h0);
        // flags a source that left unused subfields nonzero
        case (mbi_pkg::mbi_shape_e'(shape))
            mbi_pkg::SH_16X16: dec.unused_err = dec.sub_modes[7:2] != 6'h0;
            mbi_pkg::SH_16X8,
            mbi_pkg::SH_8X16: dec.unused_err = dec.sub_modes[7:4] != 4'h0;
            default: dec.unused_err = 1'b0;
        endcase
    end
endmodule

//--- mbi_top.sv
// macroblock inline field parser with an axi4-lite register slave
// assumes a single-outstanding axi4-lite master on the same clock
//
// Overview of operation
// - bits 7,6,5 of the structure byte are left row7, left upper, lower
// - bits 4,3,2 are top, top-right and top-left availability
// - two low bits of the structure byte give the chroma mode
// - inter sub-partition modes are bits 15:8 of dword 7
// - sub-partition mode k sits at bits 2k+1:2k of that byte
// - list-0 ref index k is byte k of dword 8
// - list-1 ref index k is byte k of dword 9
// - 16x16 intra uses only bits 3:0 of luma word 0
// - 8x8 intra block n is nibble n of luma word 0
// - 4x4 intra block n is word n/8, nibble n mod 8
// - 16x16 codes 0-3 vertical, horizontal, dc, plane; rest reserved
// - 8x8 codes 0-8 are the nine directions; 9-15 reserved
// - 4x4 codes 0-8 carry the same nine directions; 9-15 reserved
// - chroma code 0 dc, 1 horizontal, 2 vertical
// - subdivided blocks are numbered quadrant-recursively
// - the structure byte is bits 7:0 of intra dword 9
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
module mbi_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    typedef struct packed {
        mbi_pkg::mbi_state_e state;
        logic [31:0] ctrl;
        logic [31:0] dw7;
        logic [31:0] dw8;
        logic [31:0] dw9;
        logic [31:0] stat;
        logic [31:0] inter;
        logic aw_have;
        logic [7:0] awaddr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mbi_regs_s;

    localparam mbi_regs_s REGS_RST = '0;

    mbi_regs_s r_r;
    mbi_regs_s r_nxt;
    mbi_dec_if dec_bus ();

    logic intra;
    logic [3:0] blk_sel;
    logic [31:0] merged;

    function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                               input logic [31:0] val,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        apply_strb = res;
    endfunction

    assign intra = r_r.ctrl[mbi_pkg::CTRL_INTRA_BIT];
    assign blk_sel = r_r.ctrl[mbi_pkg::CTRL_SEL_LSB +: 4];

    mbi_intra_dec u_intra (
        .dw7(r_r.dw7),
        .dw8(r_r.dw8),
        .dw9(r_r.dw9),
        .mb_type(r_r.ctrl[mbi_pkg::CTRL_MBTYPE_LSB +: 5]),
        .ltf(r_r.ctrl[mbi_pkg::CTRL_LTF_BIT]),
        .sel(blk_sel),
        .dec(dec_bus.intra_src)
    );

    mbi_inter_dec u_inter (
        .dw7(r_r.dw7),
        .dw8(r_r.dw8),
        .dw9(r_r.dw9),
        .shape(r_r.ctrl[mbi_pkg::CTRL_SHAPE_LSB +: 2]),
        .sel(blk_sel[1:0]),
        .dec(dec_bus.inter_src)
    );

    always_comb begin
        r_nxt = r_r;
        merged = 32'h0;
        if (s_awvalid && r_r.awready) begin
            r_nxt.aw_have = 1'b1;
            r_nxt.awaddr = s_awaddr;
        end
        if (s_wvalid && r_r.wready) begin
            r_nxt.w_have = 1'b1;
            r_nxt.wdata = s_wdata;
            r_nxt.wstrb = s_wstrb;
        end
        if (r_r.bvalid && s_bready) begin
            r_nxt.bvalid = 1'b0;
        end
        // writes wait out the parse cycle so results match the stored words
        if (r_r.aw_have && r_r.w_have && !r_r.bvalid &&
            r_r.state == mbi_pkg::ST_IDLE) begin
            r_nxt.aw_have = 1'b0;
            r_nxt.w_have = 1'b0;
            r_nxt.bvalid = 1'b1;
            r_nxt.bresp = mbi_pkg::RESP_OKAY;
            case (r_r.awaddr)
                mbi_pkg::OFF_CTRL: begin
                    merged = apply_strb(r_r.ctrl, r_r.wdata, r_r.wstrb);
                    r_nxt.ctrl = merged & mbi_pkg::CTRL_WMASK;
                    if (merged[mbi_pkg::CTRL_START_BIT]) begin
                        r_nxt.state = mbi_pkg::ST_PARSE;
                    end
                end
                mbi_pkg::OFF_DW7: begin
                    r_nxt.dw7 = apply_strb(r_r.dw7, r_r.wdata, r_r.wstrb);
                    r_nxt.stat[mbi_pkg::STAT_VALID_BIT] = 1'b0;
                end
                mbi_pkg::OFF_DW8: begin
                    r_nxt.dw8 = apply_strb(r_r.dw8, r_r.wdata, r_r.wstrb);
                    r_nxt.stat[mbi_pkg::STAT_VALID_BIT] = 1'b0;
                end
                mbi_pkg::OFF_DW9: begin
                    r_nxt.dw9 = apply_strb(r_r.dw9, r_r.wdata, r_r.wstrb);
                    r_nxt.stat[mbi_pkg::STAT_VALID_BIT] = 1'b0;
                end
                mbi_pkg::OFF_STAT, mbi_pkg::OFF_INTER, mbi_pkg::OFF_SCAN: begin
                    r_nxt.bresp = mbi_pkg::RESP_OKAY;
                end
                default: r_nxt.bresp = mbi_pkg::RESP_SLVERR;
            endcase
        end
        case (r_r.state)
            mbi_pkg::ST_PARSE: begin
                r_nxt.state = mbi_pkg::ST_IDLE;
                r_nxt.stat = 32'h0;
                r_nxt.stat[mbi_pkg::STAT_VALID_BIT] = 1'b1;
                r_nxt.stat[mbi_pkg::STAT_INTRA_BIT] = intra;
                r_nxt.stat[mbi_pkg::STAT_RSV_BIT] =
                    intra & dec_bus.intra_rsv_err;
                r_nxt.stat[mbi_pkg::STAT_MBZ_BIT] = intra ?
                    dec_bus.intra_mbz_err : dec_bus.inter_mbz_err;
                r_nxt.stat[mbi_pkg::STAT_SIZE_LSB +: 2] = dec_bus.size;
                r_nxt.stat[mbi_pkg::STAT_CODE_LSB +: 4] = dec_bus.luma_code;
                r_nxt.stat[mbi_pkg::STAT_MODE_LSB +: 4] = dec_bus.luma_mode;
                r_nxt.stat[mbi_pkg::STAT_CHROMA_LSB +: 2] =
                    dec_bus.chroma;
                r_nxt.stat[mbi_pkg::STAT_AVAIL_LSB +: 6] =
                    dec_bus.avail;
                r_nxt.inter = 32'h0;
                r_nxt.inter[mbi_pkg::INT_L0_LSB +: 8] = dec_bus.ref_l0;
                r_nxt.inter[mbi_pkg::INT_L1_LSB +: 8] = dec_bus.ref_l1;
                r_nxt.inter[mbi_pkg::INT_SUB_LSB +: 2] = dec_bus.sub_mode;
                r_nxt.inter[mbi_pkg::INT_UNUSED_BIT] =
                    !intra & dec_bus.unused_err;
                r_nxt.inter[mbi_pkg::INT_MBZ_BIT] =
                    !intra & dec_bus.inter_mbz_err;
                r_nxt.inter[mbi_pkg::INT_ALL_LSB +: 8] = dec_bus.sub_modes;
            end
            default: begin
            end
        endcase
        if (r_r.rvalid && s_rready) begin
            r_nxt.rvalid = 1'b0;
        end
        if (s_arvalid && r_r.arready) begin
            r_nxt.rvalid = 1'b1;
            r_nxt.rresp = mbi_pkg::RESP_OKAY;
            case (s_araddr)
                mbi_pkg::OFF_CTRL: r_nxt.rdata = r_r.ctrl;
                mbi_pkg::OFF_DW7: r_nxt.rdata = r_r.dw7;
                mbi_pkg::OFF_DW8: r_nxt.rdata = r_r.dw8;
                mbi_pkg::OFF_DW9: r_nxt.rdata = r_r.dw9;
                mbi_pkg::OFF_STAT: r_nxt.rdata = r_r.stat;
                mbi_pkg::OFF_INTER: r_nxt.rdata = r_r.inter;
                mbi_pkg::OFF_SCAN: r_nxt.rdata = {28'h0,
                    mbi_pkg::raster_to_block(
                        r_r.ctrl[mbi_pkg::CTRL_RASTER_LSB +: 4])};
                default: begin
                    r_nxt.rdata = 32'h0;
                    r_nxt.rresp = mbi_pkg::RESP_SLVERR;
                end
            endcase
        end
        // readies registered so every port comes from a flop
        r_nxt.awready = !r_nxt.aw_have && !r_nxt.bvalid;
        r_nxt.wready = !r_nxt.w_have && !r_nxt.bvalid;
        r_nxt.arready = !r_nxt.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_r <= REGS_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign s_awready = r_r.awready;
    assign s_wready = r_r.wready;
    assign s_bresp = r_r.bresp;
    assign s_bvalid = r_r.bvalid;
    assign s_arready = r_r.arready;
    assign s_rdata = r_r.rdata;
    assign s_rresp = r_r.rresp;
    assign s_rvalid = r_r.rvalid;

    // expected values built straight from the stored words
    logic [1:0] exp_sub;
    logic [7:0] exp_l0;
    logic [7:0] exp_l1;
    logic [3:0] exp_small;
    logic parse;
    logic small_mode;
    assign exp_sub = r_r.dw7[mbi_pkg::SUB_LSB + 2 * blk_sel[1:0] +: 2];
    assign exp_l0 = r_r.dw8[8 * blk_sel[1:0] +: 8];
    assign exp_l1 = r_r.dw9[8 * blk_sel[1:0] +: 8];
    assign exp_small = blk_sel[3] ? r_r.dw8[16 * blk_sel[2] +
        4 * blk_sel[1:0] +: 4] : r_r.dw7[16 * blk_sel[2] +
        4 * blk_sel[1:0] +: 4];
    assign parse = r_r.state == mbi_pkg::ST_PARSE;
    assign small_mode = r_r.ctrl[mbi_pkg::CTRL_MBTYPE_LSB +: 5] == 5'h00 &&
        !r_r.ctrl[mbi_pkg::CTRL_LTF_BIT];

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_parse_done;
        parse |=> r_r.state == mbi_pkg::ST_IDLE && r_r.stat[0];
    endproperty
    a_parse_done: assert property (p_parse_done) else $error("parse stuck");
    property p_left_avail;
        parse |=> r_r.stat[29:27] == $past(r_r.dw9[7:5]);
    endproperty
    a_left_avail: assert property (p_left_avail)
        else $error("left availability misplaced");
    property p_top_avail;
        parse |=> r_r.stat[26:24] == $past(r_r.dw9[4:2]);
    endproperty
    a_top_avail: assert property (p_top_avail)
        else $error("top availability misplaced");
    property p_chroma;
        parse |=> r_r.stat[17:16] == $past(r_r.dw9[1:0]);
    endproperty
    a_chroma: assert property (p_chroma)
        else $error("chroma code wrong");
    property p_sub_mode;
        parse && !intra |=> r_r.inter[17:16] == $past(exp_sub);
    endproperty
    a_sub_mode: assert property (p_sub_mode)
        else $error("sub mode wrong");
    property p_ref_l0;
        parse |=> r_r.inter[7:0] == $past(exp_l0);
    endproperty
    a_ref_l0: assert property (p_ref_l0)
        else $error("list0 index wrong");
    property p_ref_l1;
        parse |=> r_r.inter[15:8] == $past(exp_l1);
    endproperty
    a_ref_l1: assert property (p_ref_l1)
        else $error("list1 index wrong");
    property p_small;
        parse && small_mode |=> r_r.stat[11:8] == $past(exp_small);
    endproperty
    a_small: assert property (p_small)
        else $error("4x4 code wrong");
    property p_big_rsv;
        r_r.stat[0] && r_r.stat[3] && r_r.stat[5:4] == 2'b00 &&
            r_r.stat[11:8] > 4'h3
            |-> r_r.stat[1] && r_r.stat[15:12] == 4'hf;
    endproperty
    a_big_rsv: assert property (p_big_rsv)
        else $error("16x16 reserved code not flagged");
    property p_big_plane;
        r_r.stat[0] && r_r.stat[3] && r_r.stat[5:4] == 2'b00 &&
            r_r.stat[11:8] == 4'h3 |-> r_r.stat[15:12] == 4'h9;
    endproperty
    a_big_plane: assert property (p_big_plane)
        else $error("16x16 plane misdecoded");
    property p_bhold;
        s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
    property p_rhold;
        s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("rvalid dropped");

    c_intra4: cover property (parse && intra && small_mode);
    c_inter: cover property (parse && !intra);
    c_slverr: cover property (s_bvalid && s_bresp == mbi_pkg::RESP_SLVERR);
    c_read: cover property (s_rvalid && s_rready ##1 s_rvalid);
endmodule

//--- mbi_src.sv
// command source model: inline word builders and axi4-lite master
// assumes a slave on the same aclk; one write or read at a time
module mbi_src (
    input wire logic aclk,
    output logic [7:0] s_awaddr,
    output logic s_awvalid,
    output logic [31:0] s_wdata,
    output logic [3:0] s_wstrb,
    output logic s_wvalid,
    output logic s_bready,
    output logic [7:0] s_araddr,
    output logic s_arvalid,
    output logic s_rready,
    input wire logic s_awready,
    input wire logic s_wready,
    input wire logic [1:0] s_bresp,
    input wire logic s_bvalid,
    input wire logic s_arready,
    input wire logic [31:0] s_rdata,
    input wire logic [1:0] s_rresp,
    input wire logic s_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready} = '0;
        {s_araddr, s_arvalid, s_rready} = '0;
    end
    // non-mbaff: lower-left copies upper-left, row7 flag zero
    function automatic logic [31:0] sbyte(logic mbaff, logic [5:0] av,
            logic [1:0] ch);
        if (!mbaff) av = {1'b0, av[4], av[4], av[2:0]};
        return {24'h0, av, ch};
    endfunction
    // partition modes low, unused subfields zero
    // caller takes modes from sub type for 8x8, else mb type
    function automatic logic [31:0] idw7(logic [1:0] sh, logic [7:0] m);
        m &= (sh == 2'h3) ? 8'hff : (sh == 2'h0) ? 8'h03 : 8'h0f;
        return {16'h0, m, 8'h0};
    endfunction
    task automatic wr(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {s_awaddr, s_wdata, s_wstrb} <= {a, d, 4'hf};
        {s_awvalid, s_wvalid, s_bready} <= 3'h7;
        // no own limit: only the bench timeout ends a hung wait
        do begin
            @(posedge aclk);
            // released lines stop showing the old value
            if (s_awready) {s_awvalid, s_awaddr} <= {1'b0, ~a};
            if (s_wready) {s_wvalid, s_wdata} <= {1'b0, ~d};
        end while (s_bvalid !== 1'b1);
        r = s_bresp;
        s_bready <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, output logic [31:0] d,
            output logic [1:0] r);
        @(posedge aclk);
        {s_araddr, s_arvalid, s_rready} <= {a, 2'h3};
        do begin
            @(posedge aclk);
            if (s_arready) {s_arvalid, s_araddr} <= {1'b0, ~a};
        end while (s_rvalid !== 1'b1);
        {d, r} = {s_rdata, s_rresp};
        s_rready <= 1'b0;
    endtask
endmodule

//--- tb_mbi_top.sv
// self-checking bench of the inline field parser
// assumes mbi_top and the source model mbi_src
module tb_mbi_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, rv;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp, rr;
    logic [63:0] qtab = 64'hfeba_dc98_7632_5410;
    int errors = 0, checked = 0, cyc = 0;
    mbi_top u_mbi_top (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
        .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready));
    mbi_src u_mbi_src (.aclk(aclk), .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
        .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic summarize;
        if (errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // bound well above the ~770 cycles the sequence needs
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 10000) begin
            errors++;
            summarize();
        end
    end
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    task automatic rdc(logic [7:0] a, logic [31:0] e);
        u_mbi_src.rd(a, rv, rr);
        chk($sformatf("reg %h", a), rv, e);
    endtask
    task automatic parse(logic [31:0] ctl, w7, w8, w9);
        u_mbi_src.wr(8'h04, w7, rr);
        u_mbi_src.wr(8'h08, w8, rr);
        u_mbi_src.wr(8'h0c, w9, rr);
        u_mbi_src.wr(8'h00, ctl | 32'h80000000, rr);
    endtask
    function automatic logic [31:0] es(logic rsv, mbz, logic [1:0] sz,
            logic [3:0] c, m, logic [1:0] ch, logic [5:0] av);
        return {2'h0, av, 6'h0, ch, m, c, 2'h0, sz, 1'b1, mbz, rsv, 1'b1};
    endfunction
    initial begin
        logic [31:0] w;
        logic [63:0] q;
        logic [3:0] c, m, s;
        logic big;
        aresetn = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            w = u_mbi_src.sbyte(i != 0, 6'h2d ^ 6'(i), 2'(i));
            m = (i < 3) ? 4'(i) : (i == 3) ? 4'h9 : 4'hf;
            // i == 5 is an undefined intra type: no size, no code
            parse({19'h0, (i == 2) ? 5'h18 : (i == 5) ? 5'h19 : 5'h01, 8'h01},
                32'(i) | ((i == 1) ? 32'h100 : 32'h0), 32'h0, w);
            rdc(8'h10, es(i >= 4, i == 1, (i == 5) ? 2'h3 : 2'h0,
                (i == 5) ? 4'h0 : 4'(i), m, 2'(i),
                w[7:2]));
        end
        w = u_mbi_src.sbyte(1'b1, 6'h3f, 2'h1);
        for (int k = 0; k < 20; k++) begin
            big = k < 4;
            s = big ? 4'(k) : 4'(k - 4);
            q = big ? 64'h8931 : 64'hfedcba98_76543210;
            c = q[4 * s +: 4];
            m = (c > 4'h8) ? 4'hf : c;
            parse({12'h0, s, 14'h0, big, 1'b1}, q[31:0], q[63:32], w);
            rdc(8'h10, es(c > 4'h8, 1'b0, big ? 2'h1 : 2'h2, c, m, 2'h1,
                w[7:2]));
        end
        q = 64'h88776655_44332211;
        for (int k = 0; k < 5; k++) begin
            s = 4'(k & 3);
            w = (k < 4) ? u_mbi_src.idw7(2'h3, 8'he4) : 32'h00010c00;
            parse({12'h0, s, 12'h0, (k < 4) ? 4'hc : 4'h0}, w, q[31:0],
                q[63:32]);
            rdc(8'h14, {w[15:8], 4'h0, k == 4, k == 4, s[1:0],
                q[32 + 8 * s +: 8],
                q[8 * s +: 8]});
        end
        for (int p = 0; p < 16; p++) begin
            u_mbi_src.wr(8'h00, {8'h0, 4'(p), 20'h0}, rr);
            rdc(8'h18, {28'h0, qtab[4 * p +: 4]});
            rdc(8'h00, {8'h0, 4'(p), 20'h0});
        end
        u_mbi_src.rd(8'h1c, rv, rr);
        chk("rresp", {30'h0, rr}, 32'h2);
        chk("rdata", rv, 32'h0);
        u_mbi_src.wr(8'h20, 32'h1, rr);
        chk("bresp", {30'h0, rr}, 32'h2);
        summarize();
    end
endmodule
